// [include/mfs_consts.vh]
// Constants for the multi-function light switch: register map, fields, resets and timing.
`ifndef MFS_CONSTS_VH
`define MFS_CONSTS_VH
// Register byte offsets.
`define MFS_OFF_CTRL 8'h00
`define MFS_OFF_TOFF 8'h04
`define MFS_OFF_TLATCH 8'h08
`define MFS_OFF_TWSTART 8'h0c
`define MFS_OFF_TWLEN 8'h10
`define MFS_OFF_STATUS 8'h14
`define MFS_OFF_ELAPSED 8'h18
// Control register fields.
`define MFS_CTRL_WARN_EN 0
`define MFS_CTRL_RETAIN 1
`define MFS_CTRL_CLEAR 2
`define MFS_CTRL_POWER_FAIL 3
// Status register fields.
`define MFS_STAT_OUT 0
`define MFS_STAT_DELAY 1
`define MFS_STAT_LATCH 2
`define MFS_STAT_TRG 3
`define MFS_STAT_WARN 4
// Reset values.
`define MFS_RST_CTRL 32'h0000_0000
`define MFS_RST_TOFF 32'h0000_0064
`define MFS_RST_TLATCH 32'h0000_000a
`define MFS_RST_TWSTART 32'h0000_000f
`define MFS_RST_TWLEN 32'h0000_0001
// Timebase: clock rate in Hz and tick period in microseconds.
`define MFS_CLK_HZ 20000000
`define MFS_TICK_US 100000
`define MFS_TICK_CYCLES ((`MFS_CLK_HZ / 1000000) * `MFS_TICK_US)
`endif

// [design/mfs_light_switch.v]
// Multi-function light switch: pulse switch with off-delay, latch and warning, AHB-Lite slave.
//
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "mfs_consts.vh"

module mfs_light_switch #(
    parameter TW = 16,
    parameter TICK_CYCLES = `MFS_TICK_CYCLES
) (
    // Clock and reset.
    input wire clk_sys,
    input wire rst_n,
    // AHB-Lite slave.
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // Pushbutton, reset pin and lamp.
    input wire trg_pin,
    input wire clr_pin,
    output reg lamp_out
);
    localparam ST_OFF = 2'd0;
    localparam ST_PRESS = 2'd1;
    localparam ST_DELAY = 2'd2;
    localparam ST_LATCH = 2'd3;
    // OFF waits for a press, PRESS times the hold, DELAY runs the off-delay and
    // LATCH keeps the lamp on until the next press or a clear.

    // The control reset value is kept at bus width; only its stored low bits are used.
    localparam [31:0] RST_CTRL = `MFS_RST_CTRL;

    reg [3:0] ctrl;
    reg [TW-1:0] t_off;
    reg [TW-1:0] t_latch;
    reg [TW-1:0] t_wstart;
    reg [TW-1:0] t_wlen;
    reg [1:0] state;
    reg [TW-1:0] elapsed;
    reg [31:0] div_cnt;
    reg tick;
    reg [2:0] trg_sync;
    reg [2:0] clr_sync;
    reg trg_lvl;
    reg clr_lvl;
    reg trg_prev;
    reg clr_prev;
    reg wr_pend;
    reg [7:0] wr_addr;
    reg warn_act;
    reg [1:0] next_state;

    wire trg_rise;
    wire trg_fall;
    wire clr_rise;
    wire clr_cmd;
    wire pwr_clear;
    wire addr_phase;
    wire [TW-1:0] warn_at;
    wire [TW-1:0] warn_end;
    wire warn_now;
    wire [7:0] rd_word;

    // Field extraction from a bus word, used for every time register.
    // Bits above TW are dropped, so software sees them read back as zero.
    function [TW-1:0] time_field;
        input [31:0] word;
        begin
            time_field = word[TW-1:0];
        end
    endfunction

    // Zero-extend a status or time value to the bus width.
    // TW must stay below 32, or the zero fill would be empty.
    function [31:0] widen;
        input [TW-1:0] val;
        begin
            widen = {{(32-TW){1'b0}}, val};
        end
    endfunction

    // Pins come from outside the clock domain; a change counts when stages two and three agree.
    // Stage one is read only by stage two, so a metastable first stage never reaches logic.
    // The agreement filter also swallows a single-cycle glitch on the contact.
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            trg_sync <= 3'h0;
            clr_sync <= 3'h0;
            trg_lvl <= 1'b0;
            clr_lvl <= 1'b0;
            trg_prev <= 1'b0;
            clr_prev <= 1'b0;
        end
        else
        begin
            trg_sync <= {trg_sync[1:0], trg_pin};
            clr_sync <= {clr_sync[1:0], clr_pin};
            if (trg_sync[1] == trg_sync[2])
                trg_lvl <= trg_sync[2];
            if (clr_sync[1] == clr_sync[2])
                clr_lvl <= clr_sync[2];
            trg_prev <= trg_lvl;
            clr_prev <= clr_lvl;
        end
    end

    assign trg_rise = trg_lvl & ~trg_prev;
    assign trg_fall = ~trg_lvl & trg_prev;
    assign clr_rise = clr_lvl & ~clr_prev;

    // Timebase divider: a one-cycle enable per tick, restarted whenever timing restarts.
    // Restarting keeps every interval a whole number of ticks from its start; the cost is
    // that a timed interval can never be shorter than its count of full ticks.
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            div_cnt <= 32'h0;
            tick <= 1'b0;
        end
        else if (trg_rise || trg_fall || clr_cmd)
        begin
            div_cnt <= 32'h0;
            tick <= 1'b0;
        end
        else if (div_cnt == TICK_CYCLES - 1)
        begin
            div_cnt <= 32'h0;
            tick <= 1'b1;
        end
        else
        begin
            div_cnt <= div_cnt + 32'h1;
            tick <= 1'b0;
        end
    end

    // A software power-fail event clears state only while retention is off.
    // Retention in force before the write decides, not the bits written with the event.
    assign pwr_clear = wr_pend && (wr_addr == `MFS_OFF_CTRL) &&
        hwdata[`MFS_CTRL_POWER_FAIL] && !ctrl[`MFS_CTRL_RETAIN];
    assign clr_cmd = clr_rise || pwr_clear ||
        (wr_pend && (wr_addr == `MFS_OFF_CTRL) && hwdata[`MFS_CTRL_CLEAR]);

    // Warning window bounds; a start beyond the off-delay clamps to zero.
    // A window that runs past the off-delay is simply cut short by the switch-off.
    assign warn_at = (t_wstart > t_off) ? {TW{1'b0}} : t_off - t_wstart;
    assign warn_end = warn_at + t_wlen;

    // The window applies only while the off-delay already runs: on the release cycle
    // elapsed still holds the press count, which must not blank the lamp.
    assign warn_now = (state == ST_DELAY) && (next_state == ST_DELAY) &&
        ctrl[`MFS_CTRL_WARN_EN] && (t_wlen != {TW{1'b0}}) &&
        (elapsed >= warn_at) && (elapsed < warn_end);

    // Next-state decision for the switch sequencer.
    // Clear sources are applied last, so they win over a trigger edge in the same cycle.
    always @*
    begin
        next_state = state;
        case (state)
            ST_OFF:
                if (trg_rise)
                    next_state = ST_PRESS;
            ST_PRESS:
                if (trg_fall)
                    next_state = ST_DELAY;
                else if (elapsed >= t_latch)
                    next_state = ST_LATCH;
            ST_DELAY:
                if (trg_rise)
                    next_state = ST_OFF;
                else if (elapsed == t_off)
                    next_state = ST_OFF;
            ST_LATCH:
                if (trg_rise)
                    next_state = ST_OFF;
            default:
                next_state = ST_OFF;
        endcase
        if (clr_cmd)
            next_state = ST_OFF;
    end

    // Sequencer, elapsed count and lamp drive.
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            state <= ST_OFF;
            elapsed <= {TW{1'b0}};
            warn_act <= 1'b0;
            lamp_out <= 1'b0;
        end
        else
        begin
            state <= next_state;
            // A state change, latching or idling all restart the count from zero.
            if (next_state != state || next_state == ST_LATCH || next_state == ST_OFF)
                elapsed <= {TW{1'b0}};
            // The count stops at full scale rather than wrapping back through small values.
            else if (tick && elapsed != {TW{1'b1}})
                elapsed <= elapsed + {{(TW-1){1'b0}}, 1'b1};
            // Warning drops the lamp from warn_at until warn_at plus its length.
            warn_act <= warn_now;
            // The lamp is registered so the output pin never sees decode glitches.
            lamp_out <= (next_state != ST_OFF) && !warn_now;
        end
    end

    // Only NONSEQ or SEQ with the bus ready is a transfer; IDLE and BUSY are ignored.
    assign addr_phase = hsel && hready && htrans[1];
    // Word address of a read in its address phase; byte lanes are not decoded.
    assign rd_word = {haddr[7:2], 2'b00};

    // AHB-Lite slave: zero wait states, always OKAY; writes land in the data phase.
    // The write address is kept for the data phase, when hwdata is finally valid.
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= addr_phase && hwrite;
            wr_addr <= {haddr[7:2], 2'b00};
            if (addr_phase && !hwrite)
            begin
                if (rd_word == `MFS_OFF_CTRL)
                    hrdata <= {30'h0, ctrl[`MFS_CTRL_RETAIN:`MFS_CTRL_WARN_EN]};
                else if (rd_word == `MFS_OFF_TOFF)
                    hrdata <= widen(t_off);
                else if (rd_word == `MFS_OFF_TLATCH)
                    hrdata <= widen(t_latch);
                else if (rd_word == `MFS_OFF_TWSTART)
                    hrdata <= widen(t_wstart);
                else if (rd_word == `MFS_OFF_TWLEN)
                    hrdata <= widen(t_wlen);
                // Status is sampled in the address phase and stands through the data phase.
                else if (rd_word == `MFS_OFF_STATUS)
                    hrdata <= {27'h0, warn_act, trg_lvl, state == ST_LATCH,
                        state == ST_DELAY, lamp_out};
                else if (rd_word == `MFS_OFF_ELAPSED)
                    hrdata <= widen(elapsed);
                else
                    hrdata <= 32'h0;
            end
        end
    end

    // Configuration registers; all times share one timebase set by the tick.
    // Clear and power-fail are pulses acting in the data phase; only two bits are stored.
    // Writes to the read-only status and elapsed words fall through and are ignored.
    always @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            ctrl <= RST_CTRL[3:0];
            t_off <= time_field(`MFS_RST_TOFF);
            t_latch <= time_field(`MFS_RST_TLATCH);
            t_wstart <= time_field(`MFS_RST_TWSTART);
            t_wlen <= time_field(`MFS_RST_TWLEN);
        end
        else if (wr_pend)
        begin
            if (wr_addr == `MFS_OFF_CTRL)
                ctrl <= {2'b00, hwdata[`MFS_CTRL_RETAIN:`MFS_CTRL_WARN_EN]};
            else if (wr_addr == `MFS_OFF_TOFF)
                t_off <= time_field(hwdata);
            else if (wr_addr == `MFS_OFF_TLATCH)
                t_latch <= time_field(hwdata);
            else if (wr_addr == `MFS_OFF_TWSTART)
                t_wstart <= time_field(hwdata);
            else if (wr_addr == `MFS_OFF_TWLEN)
                t_wlen <= time_field(hwdata);
        end
    end
endmodule // mfs_light_switch
`default_nettype wire

// [testbench/mfs_props.sv]
// Port-level assertions for the light switch, bound to its top.
`timescale 1ns/1ns
`default_nettype none
module mfs_props (
    // Clock, reset and bus.
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins.
    input wire logic trg_pin,
    input wire logic clr_pin,
    input wire logic lamp_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [7:0] dark;
    logic [7:0] lit;
    logic wc;
    logic ru;
    logic ret;
    wire tk = hsel && hready && htrans[1];
    // Lamp run lengths; a long dark run rules out a warning gap.
    always @(posedge clk_sys)
    begin
        dark <= (!rst_n || lamp_out) ? 8'h00 : dark + {7'h00, dark != 8'hff};
        lit <= (!rst_n || !lamp_out) ? 8'h00 : lit + {7'h00, lit != 8'hff};
        wc <= rst_n && tk && hwrite && haddr == 8'h00;
        ru <= rst_n && tk && !hwrite && haddr > 8'h18;
        ret <= rst_n && (wc ? hwdata[1] : ret); // Retention in force before a write.
    end
    sequence s_press;
        (!trg_pin && dark >= 8'h40) ##1 (trg_pin && !clr_pin)[*8];
    endsequence
    sequence s_repress;
        (lamp_out && !trg_pin && lit >= 8'h40)[*8] ##1 trg_pin[*8];
    endsequence
    AST_READY: assert property (hreadyout && !hresp)
        else $error("bus stalled");
    AST_UNMAP: assert property (ru |-> hrdata == 32'h0)
        else $error("unmapped read");
    AST_ON: assert property (s_press |-> lamp_out)
        else $error("press unlit");
    AST_HOLD: assert property (
        (lamp_out && trg_pin) ##1 !trg_pin |=> lamp_out[*8]) else $error("early drop");
    AST_TOGGLE: assert property (s_repress |-> !lamp_out)
        else $error("repress kept lamp");
    AST_CLR: assert property (
        (!trg_pin && $rose(clr_pin)) ##1 (clr_pin && !trg_pin)[*7] |-> !lamp_out)
        else $error("pin clear failed");
    AST_SWCLR: assert property (wc && hwdata[2] |=> ##[0:1] !lamp_out)
        else $error("soft clear failed");
    AST_PFAIL: assert property (
        wc && hwdata[3] && !ret |=> ##[0:1] !lamp_out) else $error("power loss kept");
endmodule // mfs_props
bind mfs_light_switch mfs_props u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trg_pin(trg_pin), .clr_pin(clr_pin),
    .lamp_out(lamp_out)
);
`default_nettype wire

// [testbench/mfs_btn.sv]
// Pushbutton and lamp load model for the light switch bench.
`timescale 1ns/1ns
`default_nettype none
module mfs_btn (
    // Clock and lamp.
    input wire logic clk_sys,
    input wire logic lamp_out,
    // Contact.
    output logic trg_pin
);
    int falls = 0;
    initial trg_pin = 1'b0;
    // The load counts switch-offs, so a warning blink shows as an extra one.
    always @(negedge lamp_out) falls++;
    // Contact closes n cycles, then rests long enough for the input filter.
    task press(input int n);
        trg_pin <= 1'b1;
        repeat (n) @(posedge clk_sys);
        trg_pin <= 1'b0;
        repeat (12) @(posedge clk_sys);
    endtask
endmodule // mfs_btn
`default_nettype wire

// [testbench/tb.sv]
// Self-checking bench for the light switch.
`timescale 1ns/1ns
`default_nettype none
`include "mfs_consts.vh"
module tb;
    localparam logic [7:0] ST = `MFS_OFF_STATUS;
    localparam logic [7:0] CT = `MFS_OFF_CTRL;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic clr_pin = 1'b0;
    logic rdp = 1'b0;
    logic [15:0] rnd = 16'h003b;
    logic [71:0] e;
    logic [71:0] q[$];
    logic [31:0] cw[3] = '{32'h4, 32'h8, 32'ha};
    wire [31:0] hrdata;
    wire hready;
    wire hresp;
    wire trg_pin;
    wire lamp_out;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    mfs_light_switch #(.TICK_CYCLES(4)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hready), .hresp(hresp), .trg_pin(trg_pin), .clr_pin(clr_pin),
        .lamp_out(lamp_out)
    );
    mfs_btn btn (.clk_sys(clk_sys), .lamp_out(lamp_out), .trg_pin(trg_pin));
    // Clock at 20 MHz.
    always #25 clk_sys = ~clk_sys;
    function logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task report_and_stop;
        if (n_errors == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // One single transfer; the bus goes IDLE in the data phase, so no next address phase overlaps it.
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsize <= 3'h2;
        @(posedge clk_sys);
        while (!hready) @(posedge clk_sys);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk_sys);
        while (!hready) @(posedge clk_sys);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        q.push_back({a, m, x});
        xfer(a, 1'b0, 32'h0);
    endtask
    // Each finished read retires the oldest note; a hang ends the run.
    always @(posedge clk_sys)
    begin
        cyc++;
        if (rdp)
        begin
            e = q.pop_front();
            chk($sformatf("reg %h", e[71:64]), hrdata & e[63:32], e[31:0]);
        end
        rdp <= hsel && hready && htrans[1] && !hwrite;
        if (cyc > 20000)
        begin
            n_errors++;
            report_and_stop();
        end
    end
    initial
    begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(CT, 32'hffffffff, `MFS_RST_CTRL);
        rd(`MFS_OFF_TOFF, 32'hffffffff, `MFS_RST_TOFF);
        rd(`MFS_OFF_TLATCH, 32'hffffffff, `MFS_RST_TLATCH);
        rd(`MFS_OFF_TWSTART, 32'hffffffff, `MFS_RST_TWSTART);
        rd(`MFS_OFF_TWLEN, 32'hffffffff, `MFS_RST_TWLEN);
        rd(8'h1c, 32'hffffffff, 32'h0);
        for (int i = 1; i < 5; i++)
        begin
            rnd = lfsr(rnd);
            xfer(8'(4 * i), 1'b1, {rnd, rnd});
            rd(8'(4 * i), 32'hffffffff, {16'h0, rnd});
        end
        // Off-delay 10 ticks, latch 10, warning from 4 ticks before for 2.
        xfer(`MFS_OFF_TOFF, 1'b1, 32'ha);
        xfer(`MFS_OFF_TLATCH, 1'b1, 32'ha);
        xfer(`MFS_OFF_TWSTART, 1'b1, 32'h4);
        xfer(`MFS_OFF_TWLEN, 1'b1, 32'h2);
        for (int w = 0; w < 2; w++)
        begin
            xfer(CT, 1'b1, 32'(w));
            btn.falls = 0;
            btn.press(12);
            rd(ST, 32'h3, 32'h3);
            repeat (18) @(posedge clk_sys);
            rd(ST, 32'h1f, w ? 32'h12 : 32'h3);
            repeat (40) @(posedge clk_sys);
            rd(ST, 32'h7, 32'h0);
            chk("lamp falls", 32'(btn.falls), 32'(w + 1));
        end
        btn.press(60);
        repeat (100) @(posedge clk_sys);
        rd(ST, 32'h7, 32'h5);
        btn.press(12);
        rd(ST, 32'h7, 32'h0);
        btn.press(12);
        btn.press(12);
        rd(ST, 32'h7, 32'h0);
        btn.press(12);
        clr_pin <= 1'b1;
        repeat (10) @(posedge clk_sys);
        clr_pin <= 1'b0;
        rd(ST, 32'h7, 32'h0);
        rd(`MFS_OFF_ELAPSED, 32'hffff, 32'h0);
        for (int k = 0; k < 3; k++)
        begin
            btn.press(60);
            if (k == 2)
                xfer(CT, 1'b1, 32'h2);
            xfer(CT, 1'b1, cw[k]);
            rd(ST, 32'h1, {31'h0, k == 2});
        end
        rd(CT, 32'h6, 32'h2);
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
